// file: core/sfe_regs.svh
// Constants for the serial flash front end: opcodes, counts, reset and idle values.
// Assumes inclusion by bare name from the design files.
`ifndef SFE_REGS_SVH
`define SFE_REGS_SVH
`define SFE_OP_DUAL_OUT   8'h3B
`define SFE_OP_DUAL_IO    8'hBB
`define SFE_OP_QUAD_OUT   8'h6B
`define SFE_OP_QUAD_IO    8'hEB
`define SFE_OP_QUAD_WORD  8'hE7
`define SFE_OP_QUAD_OCTAL 8'hE3
`define SFE_OP_WRITE_STAT 8'h01
`define SFE_OPC_BITS      4'h8
`define SFE_SYNC_RST      2'h0
`define SFE_PIN_IDLE      7'h5E
`define SFE_BYTE_ZERO     8'h00
`endif

// file: core/sfe_pkg.sv
// Types shared by the serial flash front end and its bench.
// Assumes sfe_regs.svh is available for numeric constants.
package sfe_pkg;
    // Lane width of the current phase
    typedef enum logic [1:0] {
        SFE_W_SINGLE,
        SFE_W_DUAL,
        SFE_W_QUAD
    } sfe_width_t;

    // Decoder progress within a frame
    typedef enum logic [1:0] {
        SFE_ST_IDLE,
        SFE_ST_OPCODE,
        SFE_ST_BODY
    } sfe_state_t;

    // One received byte handed to the core
    typedef struct packed {
        logic       first;
        logic [7:0] data;
    } sfe_rx_byte_t;

    // Four data lanes as seen or driven on the pins
    typedef struct packed {
        logic [3:0] lanes;
    } sfe_lanes_t;
endpackage : sfe_pkg

// file: core/sfe_sync.sv
// Two flip-flop synchroniser for a bundle of pin inputs.
// Assumes inputs are asynchronous to sys_clk_i.
`timescale 1ns/1ns
`include "sfe_regs.svh"
module sfe_sync #(
    parameter int WIDTH = 7
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rstn_i,
    input  wire logic [WIDTH-1:0] async_i,
    input  wire logic [WIDTH-1:0] rst_val_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;
    logic [1:0]       fill_r;

    // First stage is read only by the second stage
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_r <= '0;
            sync_r <= '0;
            fill_r <= `SFE_SYNC_RST;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
            fill_r <= {fill_r[0], 1'b1};
        end
    end

    // Idle levels in reset and until the chain has filled, so no false edge appears
    assign sync_o = fill_r[1] ? sync_r : rst_val_i;
endmodule : sfe_sync

// file: core/sfe_spi_front.sv
// Serial flash SPI front end: framing, opcode decode, lane control, hold and WP.
// Assumes sys_clk_i runs far faster than the serial clock so every pin edge is seen.
//
// Contract
// RQ1: Chip select high keeps every data lane released.
// RQ2: No instruction accepted until chip select falls after reset.
// RQ3: Single-lane input bits sampled on rising serial clock.
// RQ4: Single-lane output driven on falling serial clock.
// RQ5: Dual and quad lanes sample on rising, drive on falling edges.
// RQ6: Quad works only with quad_enable; pins become dq2 and dq3.
// RQ7: Clock modes 0 and 3 both supported.
// RQ8: Opcodes 3Bh and BBh make dq0 and dq1 bidirectional.
// RQ9: Quad opcodes use dq0 to dq3 in pin order.
// RQ10: Write-protect pin gates status writes, unused when quad_enable set.
// RQ11: Hold releases output and ignores serial_in and clock.
// RQ12: Hold honoured only in single and dual operation.
// RQ13: Hold starts at hold_n fall if clock low, else next clock fall.
// RQ14: Hold ends at hold_n rise if clock low, else next clock fall.
// RQ15: Partial instruction and data are kept through a hold.
// RQ16: Master should keep chip select low throughout a hold.
// RQ17: Hardware protection mode with write-protect low refuses status writes.
// RQ18: Chip select rising ends transaction and resets decoder.
`timescale 1ns/1ns
`include "sfe_regs.svh"
module sfe_spi_front (
    input  wire logic             sys_clk_i,
    input  wire logic             rstn_i,
    input  wire logic             cs_n_i,
    input  wire logic             sclk_i,
    input  wire logic [3:0]       dq_i,
    output logic      [3:0]       dq_o,
    output logic      [3:0]       dq_oe_n_o,
    input  wire logic             quad_enable_i,
    input  wire logic             protect_mode_hi_i,
    input  wire logic             protect_mode_lo_i,
    input  wire logic [7:0]       tx_data_i,
    input  wire logic             tx_quad_addr_i,
    output sfe_pkg::sfe_rx_byte_t rx_byte_o,
    output logic                  rx_valid_o,
    output logic                  tx_req_o,
    output logic [7:0]            opcode_o,
    output logic                  opcode_valid_o,
    output logic                  stat_write_ok_o,
    output logic                  hold_o,
    output logic                  frame_end_o
);
    logic [6:0] pins_s;
    logic       cs_n_s, sclk_s, sclk_d_r, cs_n_d_r, armed_r, hold_r;
    logic [3:0] dq_s;
    logic       sclk_rise, sclk_fall, cs_fall, cs_rise, quad_mode, hold_pin_n, wp_pin_n;
    sfe_pkg::sfe_state_t state_r;
    sfe_pkg::sfe_width_t in_w_r, out_w_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_in_r, shift_out_r;
    logic       out_phase_r, first_r;

    // Idle levels: cs high, clock low, lanes high
    sfe_sync #(.WIDTH(7)) u_sync (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .async_i   ({cs_n_i, sclk_i, dq_i, 1'b0}),
        .rst_val_i (`SFE_PIN_IDLE),
        .sync_o    (pins_s)
    );
    assign cs_n_s = pins_s[6];
    assign sclk_s = pins_s[5];
    assign dq_s   = pins_s[4:1];

    // Pin roles follow quad_enable [RQ6]
    assign quad_mode  = (in_w_r == sfe_pkg::SFE_W_QUAD) || (out_w_r == sfe_pkg::SFE_W_QUAD);
    assign hold_pin_n = quad_enable_i ? 1'b1 : dq_s[3];
    assign wp_pin_n   = quad_enable_i ? 1'b1 : dq_s[2];   // [RQ10]

    // Edge detection on the synchronised clock and select
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sclk_d_r <= 1'b0;
            cs_n_d_r <= 1'b1;
        end else begin
            sclk_d_r <= sclk_s;
            cs_n_d_r <= cs_n_s;
        end
    end
    assign sclk_rise = sclk_s && !sclk_d_r;
    assign sclk_fall = !sclk_s && sclk_d_r;
    assign cs_fall   = !cs_n_s && cs_n_d_r;
    assign cs_rise   = cs_n_s && !cs_n_d_r;

    // Select must fall once after reset before anything is decoded [RQ2]
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) armed_r <= 1'b0;
        else if (cs_fall) armed_r <= 1'b1;   // [RQ2]
    end

    // Hold tracks pin at clock-low, otherwise waits for the clock fall [RQ13] [RQ14]
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hold_r <= 1'b0;
        end else if (cs_n_s || quad_mode || quad_enable_i) begin
            hold_r <= 1'b0;                                  // [RQ12]
        end else if (!sclk_s) begin
            hold_r <= !hold_pin_n;                           // [RQ13] [RQ14]
        end
    end

    // Opcode decode and lane width selection [RQ8] [RQ9]
    function automatic sfe_pkg::sfe_width_t out_width(input logic [7:0] op, input logic qe);
        if (op == `SFE_OP_DUAL_OUT || op == `SFE_OP_DUAL_IO) out_width = sfe_pkg::SFE_W_DUAL;
        else if (qe && (op == `SFE_OP_QUAD_OUT || op == `SFE_OP_QUAD_IO ||
                        op == `SFE_OP_QUAD_WORD || op == `SFE_OP_QUAD_OCTAL))
            out_width = sfe_pkg::SFE_W_QUAD;                 // [RQ6]
        else out_width = sfe_pkg::SFE_W_SINGLE;
    endfunction : out_width

    function automatic sfe_pkg::sfe_width_t addr_width(input logic [7:0] op, input logic qe);
        if (op == `SFE_OP_DUAL_IO) addr_width = sfe_pkg::SFE_W_DUAL;
        else if (qe && (op == `SFE_OP_QUAD_IO || op == `SFE_OP_QUAD_WORD ||
                        op == `SFE_OP_QUAD_OCTAL))
            addr_width = sfe_pkg::SFE_W_QUAD;
        else addr_width = sfe_pkg::SFE_W_SINGLE;
    endfunction : addr_width

    function automatic logic [3:0] step(input sfe_pkg::sfe_width_t w);
        case (w)
            sfe_pkg::SFE_W_DUAL: step = 4'h2;
            sfe_pkg::SFE_W_QUAD: step = 4'h4;
            default:             step = 4'h1;
        endcase
    endfunction : step

    // Receive path: sample on rising clock, frozen during hold [RQ3] [RQ5] [RQ11] [RQ15]
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r        <= sfe_pkg::SFE_ST_IDLE;
            in_w_r         <= sfe_pkg::SFE_W_SINGLE;
            out_w_r        <= sfe_pkg::SFE_W_SINGLE;
            bit_cnt_r      <= 4'h0;
            shift_in_r     <= `SFE_BYTE_ZERO;
            first_r        <= 1'b1;
            opcode_o       <= `SFE_BYTE_ZERO;
            opcode_valid_o <= 1'b0;
            rx_byte_o      <= '0;
            rx_valid_o     <= 1'b0;
            frame_end_o    <= 1'b0;
        end else begin
            rx_valid_o     <= 1'b0;
            opcode_valid_o <= 1'b0;
            frame_end_o    <= cs_rise && armed_r;
            if (cs_n_s) begin
                state_r   <= sfe_pkg::SFE_ST_IDLE;           // [RQ18]
                in_w_r    <= sfe_pkg::SFE_W_SINGLE;
                out_w_r   <= sfe_pkg::SFE_W_SINGLE;
                bit_cnt_r <= 4'h0;
                first_r   <= 1'b1;
            end else if (cs_fall && armed_r) begin
                state_r   <= sfe_pkg::SFE_ST_OPCODE;
            end else if (cs_fall) begin
                state_r   <= sfe_pkg::SFE_ST_OPCODE;         // [RQ2]
            end else if (sclk_rise && !hold_r && state_r != sfe_pkg::SFE_ST_IDLE
                         && !out_phase_r) begin
                case (in_w_r)
                    sfe_pkg::SFE_W_QUAD: shift_in_r <= {shift_in_r[3:0], dq_s};
                    sfe_pkg::SFE_W_DUAL: shift_in_r <= {shift_in_r[5:0], dq_s[1:0]};
                    default:             shift_in_r <= {shift_in_r[6:0], dq_s[0]};
                endcase
                if (bit_cnt_r + step(in_w_r) >= `SFE_OPC_BITS) begin
                    bit_cnt_r <= 4'h0;
                    rx_valid_o     <= 1'b1;
                    rx_byte_o.first <= first_r;
                    first_r        <= 1'b0;
                    case (in_w_r)
                        sfe_pkg::SFE_W_QUAD: rx_byte_o.data <= {shift_in_r[3:0], dq_s};
                        sfe_pkg::SFE_W_DUAL: rx_byte_o.data <= {shift_in_r[5:0], dq_s[1:0]};
                        default:             rx_byte_o.data <= {shift_in_r[6:0], dq_s[0]};
                    endcase
                    if (state_r == sfe_pkg::SFE_ST_OPCODE) begin
                        opcode_o       <= {shift_in_r[6:0], dq_s[0]};
                        opcode_valid_o <= 1'b1;
                        state_r        <= sfe_pkg::SFE_ST_BODY;
                        in_w_r  <= addr_width({shift_in_r[6:0], dq_s[0]}, quad_enable_i);
                        out_w_r <= out_width({shift_in_r[6:0], dq_s[0]}, quad_enable_i);
                    end
                end else begin
                    bit_cnt_r <= bit_cnt_r + step(in_w_r);
                end
            end else if (sclk_fall && !hold_r && out_phase_r) begin
                // Count driven bits so the transmit side knows when a byte is done [RQ4]
                if (bit_cnt_r + step(out_w_r) >= `SFE_OPC_BITS) bit_cnt_r <= 4'h0;
                else bit_cnt_r <= bit_cnt_r + step(out_w_r);
            end
        end
    end

    // Transmit path: core requests a byte, driven on falling clock [RQ4] [RQ5] [RQ7]
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_phase_r <= 1'b0;
            shift_out_r <= `SFE_BYTE_ZERO;
            tx_req_o    <= 1'b0;
            dq_o        <= 4'h0;
            dq_oe_n_o   <= 4'hF;
        end else begin
            tx_req_o <= 1'b0;
            if (cs_n_s || !armed_r) begin
                out_phase_r <= 1'b0;
                dq_oe_n_o   <= 4'hF;                         // [RQ1] [RQ18]
            end else if (hold_r) begin
                dq_oe_n_o   <= 4'hF;                         // [RQ11]
            end else if (tx_quad_addr_i && !out_phase_r && state_r == sfe_pkg::SFE_ST_BODY) begin
                out_phase_r <= 1'b1;
                shift_out_r <= tx_data_i;
                tx_req_o    <= 1'b1;
            end else if (sclk_fall && out_phase_r) begin
                // Mode 3 first fall comes before the opcode, while out_phase_r is clear, so no special case
                case (out_w_r)
                    sfe_pkg::SFE_W_QUAD: begin
                        dq_o        <= shift_out_r[7:4];     // [RQ9]
                        dq_oe_n_o   <= 4'h0;
                        shift_out_r <= {shift_out_r[3:0], 4'h0};
                    end
                    sfe_pkg::SFE_W_DUAL: begin
                        dq_o        <= {2'h0, shift_out_r[7:6]};   // [RQ8]
                        dq_oe_n_o   <= 4'hC;
                        shift_out_r <= {shift_out_r[5:0], 2'h0};
                    end
                    default: begin
                        dq_o        <= {2'h0, shift_out_r[7], 1'b0};
                        dq_oe_n_o   <= 4'hD;                 // [RQ4]
                        shift_out_r <= {shift_out_r[6:0], 1'b0};
                    end
                endcase
                if (bit_cnt_r + step(out_w_r) >= `SFE_OPC_BITS) begin
                    shift_out_r <= tx_data_i;
                    tx_req_o    <= 1'b1;
                end
            end
        end
    end

    // Status write permission from protection mode and pin [RQ10] [RQ17]
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stat_write_ok_o <= 1'b0;
            hold_o          <= 1'b0;
        end else begin
            stat_write_ok_o <= !(protect_mode_hi_i) &&
                               !(protect_mode_lo_i && !wp_pin_n);   // [RQ17]
            hold_o          <= hold_r;
        end
    end
endmodule : sfe_spi_front

// file: dv/sfe_spi_front_chk.sv
// Concurrent checks on the ports of the serial flash SPI front end.
// Assumes a serial clock of at least eight system clocks, as the bench drives it.
`timescale 1ns/1ns
module sfe_spi_front_chk (
    input  wire logic       sys_clk_i,
    input  wire logic       rstn_i,
    input  wire logic       cs_n_i,
    input  wire logic       sclk_i,
    input  wire logic [3:0] dq_i,
    input  wire logic [3:0] dq_o,
    input  wire logic [3:0] dq_oe_n_o,
    input  wire logic       quad_enable_i,
    input  wire logic       protect_mode_hi_i,
    input  wire logic       protect_mode_lo_i,
    input  wire logic       rx_valid_o,
    input  wire logic       opcode_valid_o,
    input  wire logic       stat_write_ok_o,
    input  wire logic       hold_o,
    input  wire logic       frame_end_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    // Select high long enough to clear the pin synchroniser
    sequence s_desel;
        cs_n_i [*6];
    endsequence
    // Hardware protection with the pin low, pin not borrowed as a lane
    sequence s_locked;
        (!quad_enable_i && !protect_mode_hi_i && protect_mode_lo_i && !dq_i[2]) [*6];
    endsequence
    property p_idle_release;
        s_desel |-> dq_oe_n_o == 4'hF;
    endproperty
    a_idle_release: assert property (p_idle_release)
        else $error("lane driven while deselected");
    property p_frame_end;
        $rose(cs_n_i) |-> ##[2:6] frame_end_o;
    endproperty
    a_frame_end: assert property (p_frame_end)
        else $error("no frame end after select rise");
    property p_op_framed;
        opcode_valid_o |-> !$past(cs_n_i, 3);
    endproperty
    a_op_framed: assert property (p_op_framed)
        else $error("opcode taken without select");
    // Lane data moves only in the low phase that follows a clock fall
    property p_drive_fall;
        !dq_oe_n_o[1] && $changed(dq_o[1]) |-> !$past(sclk_i, 2);
    endproperty
    a_drive_fall: assert property (p_drive_fall)
        else $error("lane changed away from a clock fall");
    property p_hold_release;
        hold_o ##1 hold_o |-> dq_oe_n_o[1];
    endproperty
    a_hold_release: assert property (p_hold_release)
        else $error("output driven during hold");
    property p_hold_no_rx;
        hold_o [*3] |-> !rx_valid_o;
    endproperty
    a_hold_no_rx: assert property (p_hold_no_rx)
        else $error("byte received during hold");
    property p_quad_no_hold;
        quad_enable_i [*4] |-> !hold_o;
    endproperty
    a_quad_no_hold: assert property (p_quad_no_hold)
        else $error("hold active in quad mode");
    property p_hw_lock;
        s_locked |-> !stat_write_ok_o;
    endproperty
    a_hw_lock: assert property (p_hw_lock)
        else $error("status write allowed while locked");
endmodule : sfe_spi_front_chk

bind sfe_spi_front sfe_spi_front_chk sfe_spi_front_chk_i (
    .sys_clk_i, .rstn_i, .cs_n_i, .sclk_i, .dq_i, .dq_o, .dq_oe_n_o, .quad_enable_i,
    .protect_mode_hi_i, .protect_mode_lo_i, .rx_valid_o, .opcode_valid_o,
    .stat_write_ok_o, .hold_o, .frame_end_o
);

// file: dv/sfe_master_model.sv
// SPI bus master model for the serial flash front end, 800 ns link clock.
// Assumes the bench resolves the shared lanes and calls one task at a time, except drop, which runs alongside xfer.
`timescale 1ns/1ns
module sfe_master_model (
    output logic            cs_n_o,
    output logic            sclk_o,
    output logic [3:0]      dq_o,
    output logic [3:0]      dq_en_o,
    input  wire logic [3:0] dq_i
);
    logic       mode3_r = 1'b0;
    logic [7:0] rd_r    = 8'h00;
    // Deselected, clock low, write-protect and hold pins driven high
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        dq_o = 4'hC;
        dq_en_o = 4'hC;
    end
    // Park the clock at the idle level of the mode before selecting
    task automatic sel(input logic m3);
        mode3_r = m3;
        sclk_o = m3;
        #400 cs_n_o = 1'b0;
    endtask : sel
    // Clock back to idle before select rises, hold never open here
    task automatic desel();
        #400 sclk_o = mode3_r;
        #400 cs_n_o = 1'b1;
        dq_en_o = 4'hC;
    endtask : desel
    // Select pulled up mid-byte to abort a frame
    task automatic drop();
        #3000 cs_n_o = 1'b1;
    endtask : drop
    // Levels of write-protect and hold while they are not data lanes
    task automatic pins(input logic wp, input logic hold);
        dq_o[3:2] = {hold, wp};
    endtask : pins
    // One byte over w lanes, MSB first, launched in the low phase
    // read lanes taken late in the high phase since the device drives after the fall
    task automatic xfer(input logic [7:0] b, input int w, input logic rd);
        logic [7:0] s;
        logic [3:0] ln;
        s = b;
        dq_en_o = (w == 4) ? {4{!rd}} : {2'h3, !rd && w == 2, !rd};
        repeat (8 / w) begin
            sclk_o = 1'b0;
            if (w == 4) dq_o = s[7:4];
            else if (w == 2) dq_o[1:0] = s[7:6];
            else dq_o[0] = s[7];
            s = s << w;
            #400 sclk_o = 1'b1;
            #390 ln = (w == 4) ? dq_i : (w == 2) ? {2'h0, dq_i[1:0]} : {3'h0, dq_i[1]};
            rd_r = (rd_r << w) | {4'h0, ln};
            #10;
        end
    endtask : xfer
endmodule : sfe_master_model

// file: dv/serial_flash_spi_front_end_test.sv
// Bench for the serial flash SPI front end: reset and deselect checks, a table of read
// frames, then abort and hold cases. Assumes the master model and the bound checker.
`timescale 1ns/1ns
module serial_flash_spi_front_end_test;
    // Row: opcode, then quad enable, mode 3, protect hi, protect lo, wp pin, write ok
    typedef struct packed {
        logic [7:0] op;
        logic [5:0] f;
    } sfe_row_t;
    logic                  clk = 1'b0, rstn = 1'b0, qe = 1'b0, hi = 1'b0, lo = 1'b0;
    logic                  flip = 1'b0, tx_go = 1'b0, cs_n, sclk, rx_v, tx_req, op_v;
    logic                  ok, hold, fend;
    logic [7:0]            tx_data = 8'h00, op_seen = 8'hFF, rx_seen = 8'h00, opcode;
    logic [3:0]            m_dq, m_en, dq_pin, dq_o, dq_oe_n;
    sfe_pkg::sfe_rx_byte_t rx_byte;
    int                    errors = 0, num_checks = 0, ends = 0, reqs = 0;
    sfe_row_t              rows[8] = '{{8'h3B, 6'h04}, {8'hBB, 6'h17}, {8'h6B, 6'h25},
        {8'hEB, 6'h31}, {8'hE7, 6'h27}, {8'hE3, 6'h33}, {8'hEB, 6'h04}, {8'h6B, 6'h11}};
    always #50 clk = ~clk;
    // Released lanes: pull-ups on wp and hold, a changing pattern on the others
    always @(posedge clk) flip <= ~flip;
    assign dq_pin = (~dq_oe_n & dq_o) | (dq_oe_n & m_en & m_dq) |
                    (dq_oe_n & ~m_en & {2'h3, {2{flip}}});
    // Capture pulses so checks can run after each master step
    always @(posedge clk) begin
        if (op_v) op_seen = opcode;
        if (rx_v) rx_seen = rx_byte.data;
        ends = ends + int'(fend);
        reqs = reqs + int'(tx_req);
    end
    sfe_spi_front sfe_spi_front_i (.sys_clk_i(clk), .rstn_i(rstn), .cs_n_i(cs_n), .sclk_i(sclk),
        .dq_i(dq_pin), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n), .quad_enable_i(qe), .protect_mode_hi_i(hi),
        .protect_mode_lo_i(lo), .tx_data_i(tx_data), .tx_quad_addr_i(tx_go), .rx_byte_o(rx_byte),
        .rx_valid_o(rx_v), .tx_req_o(tx_req), .opcode_o(opcode), .opcode_valid_o(op_v),
        .stat_write_ok_o(ok), .hold_o(hold), .frame_end_o(fend));
    sfe_master_model sfe_master_model_i (.cs_n_o(cs_n), .sclk_o(sclk), .dq_o(m_dq), .dq_en_o(m_en),
        .dq_i(dq_pin));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask : tick
    // Lane widths follow the opcode; quad opcodes fall back to one lane without quad enable
    task automatic run_row(input sfe_row_t r);
        logic q, d;
        int   e0;
        q = r.f[5] && (r.op inside {8'h6B, 8'hEB, 8'hE7, 8'hE3});
        d = r.op inside {8'h3B, 8'hBB};
        e0 = ends;
        tick(1);
        {qe, hi, lo} = {r.f[5], r.f[3:2]};
        tx_data = 8'h3C;
        sfe_master_model_i.pins(r.f[1], 1'b1);
        sfe_master_model_i.sel(r.f[4]);
        sfe_master_model_i.xfer(r.op, 1, 1'b0);
        check(op_seen, r.op);
        check({7'h0, rx_byte.first}, 8'h01);
        check(ok, r.f[0]);
        sfe_master_model_i.xfer(8'hA5, (r.op == 8'hBB) ? 2 : (q && r.op != 8'h6B) ? 4 : 1, 1'b0);
        check(rx_seen, 8'hA5);
        check({7'h0, rx_byte.first}, 8'h00);
        tick(1);
        tx_go = 1'b1;
        sfe_master_model_i.xfer(8'h00, d ? 2 : q ? 4 : 1, 1'b1);
        check(sfe_master_model_i.rd_r, 8'h3C);
        sfe_master_model_i.desel();
        tick(6);
        tx_go = 1'b0;
        check(dq_oe_n, 4'hF);
        check(8'(ends - e0), 8'h01);
    endtask : run_row
    initial begin
        tick(4);
        rstn = 1'b1;
        check(dq_oe_n, 4'hF);
        sfe_master_model_i.xfer(8'hBB, 1, 1'b0);
        check(op_seen, 8'hFF);
        foreach (rows[i]) run_row(rows[i]);
        // Abort mid-opcode; the next opcode must decode from its first bit
        sfe_master_model_i.sel(1'b0);
        fork
            sfe_master_model_i.xfer(8'hEB, 1, 1'b0);
            sfe_master_model_i.drop();
        join
        check(op_seen, 8'h6B);
        sfe_master_model_i.sel(1'b0);
        sfe_master_model_i.xfer(8'h3B, 1, 1'b0);
        check(op_seen, 8'h3B);
        // Hold pin dropped and raised with the clock high: both take effect at a later fall
        sfe_master_model_i.pins(1'b1, 1'b0);
        tick(6);
        check(hold, 1'b0);
        sfe_master_model_i.xfer(8'hFF, 1, 1'b0);
        check(hold, 1'b1);
        sfe_master_model_i.pins(1'b1, 1'b1);
        tick(6);
        check(hold, 1'b1);
        sfe_master_model_i.xfer(8'h5A, 1, 1'b0);
        check(rx_seen, 8'h5A);
        check(hold, 1'b0);
        sfe_master_model_i.desel();
        check(8'(reqs > 0), 8'h01);
        print_verdict();
    end
endmodule : serial_flash_spi_front_end_test
